// file: uaec_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "uaec_cfg.svh"
// Functional notes
// - reset clears device address register
// - no response until address enable set
// - control bits select endpoint size, count
// - small layout fifos at fixed bases
// - large layout fifos at fixed bases
// - unassigned fifo regions stay plain ram
// - stall cpu three cycles per byte
// - ep0 bidirectional, others one direction
// - reset clears endpoint zero mode register
// - mode field steers ep0 response
// - ack flag set on acked transaction
// - out flag set on out token
// - in flag set on in token
// - setup flag set by engine, write clears
// - setup flag forced high data to ack
// - engine update locks lower seven bits
// - cpu read after lock releases it
// - lock only on endpoint zero mode
// - setup flag blocks cpu ep0 fifo writes
// - mode 0000 ignores tokens; ack and setup flags still set
// - setup forces mode 0001 unless disabled
module uaec_top
  import uaec_pkg::*;
#(
  parameter int STALL_CYCLES = `UAEC_STALL_CYCLES
)
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire uaec_pkg::uaec_bus_s bus,
  input  wire uaec_pkg::uaec_eng_s eng,
  input  wire logic [7:0]    ram_addr,
  input  wire logic          ram_wr,
  input  wire logic [3:0]    ep_dir_in,
  output logic [7:0]         rdata,
  output logic               addr_match,
  output uaec_pkg::uaec_rsp_e ep0_rsp,
  output logic               cpu_stall,
  output logic               ram_wr_ok,
  output logic [3:0]         ep_mode_out,
  output logic [2:0]         ep_count
);
  import uaec_pkg::*;

  // elaboration check: the stall counter is only two bits wide
  if (STALL_CYCLES < 1 || STALL_CYCLES > 3)
  begin : g_stall_range
    $error("STALL_CYCLES must be 1 to 3");
  end

  logic [7:0] dev_addr;
  logic [7:0] ep0_mode;
  logic [7:0] usb_ctrl;
  logic       ep0_lock;
  logic [1:0] stall_cnt;
  logic       setup_force;
  logic       next_match;
  logic [7:0] next_ep0;

  // every assertion below shares this clock; all but the two reset checks share this reset
  default clocking assert_clk @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // address decode helper, used only by the fifo guard
  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input logic [7:0] size);
    logic [8:0] top;
    top = {1'b0, base} + {1'b0, size};
    in_range = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
  endfunction

  // device address register, plain read/write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dev_addr <= `UAEC_RST_REG;
    else if (bus.wr && bus.addr == `UAEC_OFS_DEV_ADDR)
      dev_addr <= bus.wdata;
  end

  // status and control; only layout bits matter here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      usb_ctrl <= `UAEC_RST_REG;
    else if (bus.wr && bus.addr == `UAEC_OFS_USB_CTRL)
      usb_ctrl <= bus.wdata;
  end

  // token address check against enabled address
  always_comb
  begin
    next_match = dev_addr[`UAEC_ADDR_EN_BIT] &&
                 eng.token_addr == dev_addr[6:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      addr_match <= 1'b0;
    else
      addr_match <= eng.token_valid && next_match;
  end

  // setup flag held from data start to ack start
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      setup_force <= 1'b0;
    else if (eng.ack_start)
      setup_force <= 1'b0;
    else if (eng.setup_data)
      setup_force <= 1'b1;
  end

  // endpoint zero mode next value; engine sets win over cpu clears
  always_comb
  begin
    next_ep0 = ep0_mode;
    if (bus.wr && bus.addr == `UAEC_OFS_EP0_MODE)
    begin
      // write to setup bit always clears it, except while forced
      next_ep0[`UAEC_EP0_SETUP_BIT] = 1'b0;
      if (!ep0_lock)
        next_ep0[6:0] = bus.wdata[6:0];
      // mode bits 3:0 are inside the lock window, mode holds while locked
      if (ep0_lock)
        next_ep0[3:0] = ep0_mode[3:0];
    end
    if (eng.token_valid && next_match && eng.token_ep == 4'h0 &&
        ep0_mode[3:0] != `UAEC_MODE_DISABLE)
    begin
      next_ep0[`UAEC_EP0_OUT_BIT] = (eng.token_kind == UAEC_TOK_OUT);
      next_ep0[`UAEC_EP0_IN_BIT] = (eng.token_kind == UAEC_TOK_IN);
      if (eng.token_kind == UAEC_TOK_SETUP)
        next_ep0[3:0] = `UAEC_MODE_NAK_INOUT;
    end
    if (eng.xact_acked && eng.xact_ep == 4'h0)
      next_ep0[`UAEC_EP0_ACK_BIT] = 1'b1;
    if (eng.setup_data || setup_force)
      next_ep0[`UAEC_EP0_SETUP_BIT] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ep0_mode <= `UAEC_RST_REG;
    else
      ep0_mode <= next_ep0;
  end

  // lock: set on engine token-phase update, read releases it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ep0_lock <= 1'b0;
    else if (eng.token_valid && next_match && eng.token_ep == 4'h0 &&
             ep0_mode[3:0] != `UAEC_MODE_DISABLE)
      ep0_lock <= 1'b1;
    else if (bus.rd && bus.addr == `UAEC_OFS_EP0_MODE)
      ep0_lock <= 1'b0;
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      if (bus.addr == `UAEC_OFS_DEV_ADDR)
        rdata <= dev_addr;
      else if (bus.addr == `UAEC_OFS_EP0_MODE)
        rdata <= ep0_mode;
      else if (bus.addr == `UAEC_OFS_USB_CTRL)
        rdata <= usb_ctrl;
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end

  // endpoint zero response from mode field
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ep0_rsp <= UAEC_RSP_IGNORE;
    else
    begin
      case (ep0_mode[3:0])
        `UAEC_MODE_DISABLE:   ep0_rsp <= UAEC_RSP_IGNORE;
        `UAEC_MODE_NAK_INOUT:
          ep0_rsp <= (eng.token_kind == UAEC_TOK_SETUP) ?
                     UAEC_RSP_ACCEPT : UAEC_RSP_NAK;
        default:              ep0_rsp <= UAEC_RSP_OTHER;
      endcase
    end
  end

  // cpu stall while engine owns the data bus, per byte
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      stall_cnt <= 2'h0;
    else if (eng.fifo_wr)
      stall_cnt <= 2'(STALL_CYCLES - 1);
    else if (stall_cnt != 2'h0)
      stall_cnt <= stall_cnt - 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cpu_stall <= 1'b0;
    else
      // a running counter means the engine still owns the bus
      cpu_stall <= eng.fifo_wr || stall_cnt != 2'h0;
  end

  // ep0 fifo guard; other regions stay ordinary ram
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ram_wr_ok <= 1'b0;
    else
      ram_wr_ok <= ram_wr && !(ep0_mode[`UAEC_EP0_SETUP_BIT] &&
        in_range(ram_addr,
                 usb_ctrl[`UAEC_CTRL_SIZE_BIT] ? `UAEC_L_EP0 : `UAEC_S_EP0,
                 `UAEC_FIFO_SMALL));
  end

  // layout outputs: endpoint count and direction
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ep_count    <= 3'h3;
      ep_mode_out <= 4'h0;
    end
    else
    begin
      ep_count <= usb_ctrl[`UAEC_CTRL_COUNT_BIT] ? 3'h5 : 3'h3;
      ep_mode_out <= ep_dir_in; // data endpoints one way
    end
  end

  // assertions, clocked by the defaults above and, except the two reset checks, reset-gated by them
  sequence ep0_take_seq;
    eng.token_valid && next_match && eng.token_ep == 4'h0 &&
    ep0_mode[3:0] != 4'h0;
  endsequence

  sequence ep0_wr_seq;
    bus.wr && bus.addr == 8'h12;
  endsequence

  sequence stall_run_seq;
    cpu_stall ##1 cpu_stall ##1 cpu_stall;
  endsequence

  // reset values, so these two must not be gated by reset
  addr_rst_a: assert property (disable iff (1'b0)
    sys_rst |=> dev_addr == 8'h00)
    else $error("address register not cleared");

  mode_rst_a: assert property (disable iff (1'b0)
    sys_rst |=> ep0_mode == 8'h00)
    else $error("mode register not cleared");

  // a match needs the enable bit one edge earlier
  addr_gate_a: assert property (addr_match |-> $past(dev_addr[7]))
    else $error("match without address enable");

  match_hit_a: assert property (
    eng.token_valid && dev_addr[7] && eng.token_addr == dev_addr[6:0]
    |=> addr_match)
    else $error("enabled address not matched");

  // engine token update: flags, mode and lock
  lock_set_a: assert property (ep0_take_seq |=> ep0_lock)
    else $error("lock not taken");

  in_flag_a: assert property (
    ep0_take_seq ##0 eng.token_kind == UAEC_TOK_IN |=> ep0_mode[6:5] == 2'b10)
    else $error("in flag wrong after token");

  out_flag_a: assert property (
    ep0_take_seq ##0 eng.token_kind == UAEC_TOK_OUT |=> ep0_mode[6:5] == 2'b01)
    else $error("out flag wrong after token");

  setup_mode_a: assert property (
    ep0_take_seq ##0 eng.token_kind == UAEC_TOK_SETUP
    |=> ep0_mode[3:0] == 4'h1)
    else $error("setup did not force mode one");

  lock_rel_a: assert property (
    bus.rd && bus.addr == 8'h12 && !eng.token_valid |=> !ep0_lock)
    else $error("read did not release lock");

  locked_wr_a: assert property (
    ep0_lock ##0 ep0_wr_seq ##0 (!eng.token_valid && !eng.xact_acked)
    |=> ep0_mode[6:0] == $past(ep0_mode[6:0]))
    else $error("locked write took effect");

  // mode 0000 leaves the in and out flags alone and answers nothing
  dis_flags_a: assert property (
    eng.token_valid && ep0_mode[3:0] == 4'h0 && !bus.wr
    |=> ep0_mode[6:5] == $past(ep0_mode[6:5]))
    else $error("disabled endpoint took a token");

  dis_rsp_a: assert property (
    ep0_mode[3:0] == 4'h0 |=> ep0_rsp == UAEC_RSP_IGNORE)
    else $error("disabled endpoint answered");

  nak_rsp_a: assert property (
    ep0_mode[3:0] == 4'h1 && eng.token_kind != UAEC_TOK_SETUP
    |=> ep0_rsp == UAEC_RSP_NAK)
    else $error("mode one did not nak");

  other_rsp_a: assert property (
    ep0_mode[3:1] != 3'h0 |=> ep0_rsp == UAEC_RSP_OTHER)
    else $error("higher mode answered wrongly");

  ack_set_a: assert property (
    eng.xact_acked && eng.xact_ep == 4'h0 |=> ep0_mode[4])
    else $error("ack flag not set");

  // setup flag rises with the data packet and stays up while forced
  setup_set_a: assert property (
    eng.setup_data && !eng.ack_start |=> ep0_mode[7] && setup_force)
    else $error("setup flag not forced");

  setup_hold_a: assert property (setup_force |=> ep0_mode[7])
    else $error("setup flag dropped while forced");

  setup_clr_a: assert property (
    ep0_wr_seq ##0 !(eng.setup_data || setup_force) |=> !ep0_mode[7])
    else $error("cpu write left setup flag set");

  // ep0 fifo of the small layout is refused while setup is set
  fifo_block_a: assert property (
    ep0_mode[7] && ram_wr && ram_addr == 8'hf8 && !usb_ctrl[7]
    |=> !ram_wr_ok)
    else $error("ep0 fifo write while setup set");

  fifo_free_a: assert property (
    ram_wr && !ep0_mode[7] |=> ram_wr_ok)
    else $error("plain ram write refused");

  // endpoint count follows the count bit one edge later
  count_five_a: assert property (usb_ctrl[6] |=> ep_count == 3'h5)
    else $error("count bit set but three endpoints");

  count_three_a: assert property (
    !usb_ctrl[6] |=> ep_count == 3'h3)
    else $error("count bit clear but five endpoints");

  // stall length checked for the default span only
  stall_len_a: assert property (
    STALL_CYCLES == 3 && eng.fifo_wr && stall_cnt == 2'h0
    |=> stall_run_seq)
    else $error("cpu stall too short");

  stall_end_a: assert property (
    stall_cnt == 2'h0 && !eng.fifo_wr |=> !cpu_stall)
    else $error("cpu stall too long");
endmodule

// file: uaec_cfg.svh
`ifndef UAEC_CFG_SVH
`define UAEC_CFG_SVH
// register offsets
`define UAEC_OFS_DEV_ADDR   8'h10
`define UAEC_OFS_EP0_MODE   8'h12
`define UAEC_OFS_USB_CTRL   8'h1f
// field positions
`define UAEC_ADDR_EN_BIT    7
`define UAEC_CTRL_SIZE_BIT  7
`define UAEC_CTRL_COUNT_BIT 6
`define UAEC_EP0_SETUP_BIT  7
`define UAEC_EP0_IN_BIT     6
`define UAEC_EP0_OUT_BIT    5
`define UAEC_EP0_ACK_BIT    4
// reset values
`define UAEC_RST_REG        8'h00
// mode encodings
`define UAEC_MODE_DISABLE   4'h0
`define UAEC_MODE_NAK_INOUT 4'h1
// fifo placement, small layout
`define UAEC_S_EP0          8'hf8
`define UAEC_S_EP1          8'hf0
`define UAEC_S_EP2          8'he8
`define UAEC_S_EP3          8'he0
`define UAEC_S_EP4          8'hd8
// fifo placement, large layout
`define UAEC_L_EP0          8'hb8
`define UAEC_L_EP1          8'hc0
`define UAEC_L_EP2          8'he0
`define UAEC_L_EP3          8'ha8
`define UAEC_L_EP4          8'hb0
`define UAEC_FIFO_SMALL     8'h08
`define UAEC_FIFO_LARGE     8'h20
// stall cycles per byte written by the engine
`define UAEC_STALL_CYCLES   2'h3
`endif

// file: uaec_pkg.sv
package uaec_pkg;
  typedef enum logic [1:0]
  {
    UAEC_TOK_OUT   = 2'b00,
    UAEC_TOK_IN    = 2'b01,
    UAEC_TOK_SETUP = 2'b11,
    UAEC_TOK_NONE  = 2'b10
  } uaec_tok_e;

  // engine event bundle, one cycle pulses
  typedef struct packed
  {
    logic        token_valid;   // end of token phase
    uaec_tok_e   token_kind;
    logic [6:0]  token_addr;
    logic [3:0]  token_ep;
    logic        setup_data;    // start of setup data packet
    logic        ack_start;     // start of returned ack
    logic        xact_acked;    // transaction done with ack
    logic [3:0]  xact_ep;
    logic        fifo_wr;       // engine writes one fifo byte
  } uaec_eng_s;

  // cpu register port
  typedef struct packed
  {
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } uaec_bus_s;

  // response toward engine for endpoint zero
  typedef enum logic [1:0]
  {
    UAEC_RSP_IGNORE = 2'b00,
    UAEC_RSP_ACCEPT = 2'b01,
    UAEC_RSP_NAK    = 2'b10,
    UAEC_RSP_OTHER  = 2'b11
  } uaec_rsp_e;

  typedef enum logic [0:0]
  {
    UAEC_ST_IDLE  = 1'b0,
    UAEC_ST_STALL = 1'b1
  } uaec_st_e;
endpackage

// file: uaec_host_model.sv
`timescale 1ns/1ps
// usb host side: drives engine events as one cycle pulses
module uaec_host_model
  import uaec_pkg::*;
(
  input  wire logic          clk,
  output uaec_pkg::uaec_eng_s eng
);
  // quiet bus value: no pulses and no token kind
  function automatic uaec_eng_s quiet(input logic [6:0] a);
    uaec_eng_s q;
    q = '0;
    q.token_kind = UAEC_TOK_NONE;
    q.token_addr = a;
    return q;
  endfunction

  initial
  begin
    eng = quiet(7'h00);
  end

  // idle fields flip so a stale token address never looks valid
  task automatic idle();
    eng <= quiet(~eng.token_addr);
  endtask

  // token phase ends with one valid pulse
  task automatic token(input uaec_tok_e k, input logic [6:0] a);
    @(posedge clk);
    eng.token_valid <= 1'b1;
    eng.token_kind  <= k;
    eng.token_addr  <= a;
    eng.token_ep    <= 4'h0;
    @(posedge clk);
    idle();
  endtask

  // 0 setup data, 1 ack start, 2 acked on ep0, 3 fifo byte
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: eng.setup_data <= 1'b1;
      1: eng.ack_start  <= 1'b1;
      2: eng.xact_acked <= 1'b1;
      default: eng.fifo_wr <= 1'b1;
    endcase
    @(posedge clk);
    idle();
  endtask
endmodule

// file: usb_device_address_ep0_control_tb.sv
`timescale 1ns/1ps
module usb_device_address_ep0_control_tb;
  import uaec_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst;
  uaec_bus_s  bus;
  uaec_eng_s  eng;
  logic [7:0] ram_addr;
  logic       ram_wr;
  logic [3:0] ep_dir_in;
  logic [7:0] rdata;
  logic       addr_match;
  uaec_rsp_e  ep0_rsp;
  logic       cpu_stall;
  logic       ram_wr_ok;
  logic [3:0] ep_mode_out;
  logic [2:0] ep_count;
  logic       rd_d;
  logic [7:0] exp_q[$];
  int         fails;
  int         comparisons;
  int         seed;
  int         n;
  logic [7:0] v;

  uaec_top uaec_top_i (.clk(clk), .sys_rst(sys_rst), .bus(bus), .eng(eng),
    .ram_addr(ram_addr), .ram_wr(ram_wr), .ep_dir_in(ep_dir_in),
    .rdata(rdata), .addr_match(addr_match), .ep0_rsp(ep0_rsp),
    .cpu_stall(cpu_stall), .ram_wr_ok(ram_wr_ok),
    .ep_mode_out(ep_mode_out), .ep_count(ep_count));
  uaec_host_model uaec_host_model_i (.clk(clk), .eng(eng));

  always #4 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // register port writes and reads, one cycle strobes
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    @(posedge clk);
    bus <= {a, 8'h00, 2'b01};
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask

  task automatic ram(input logic [7:0] a, input logic e);
    @(posedge clk);
    ram_addr <= a;
    ram_wr   <= 1'b1;
    @(posedge clk);
    ram_wr <= 1'b0;
    @(negedge clk);
    chk("ram_wr_ok", 8'(ram_wr_ok), 8'(e));
  endtask

  task automatic tok(input uaec_tok_e k, input logic [6:0] a, input logic m);
    uaec_host_model_i.token(k, a);
    @(negedge clk);
    chk("addr_match", 8'(addr_match), 8'(m));
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_d <= bus.rd;
    if (rd_d)
      chk("rdata", rdata, exp_q.pop_front());
  end

  // hang guard, far beyond the roughly 115 cycles of the sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial
  begin
    sys_rst = 1'b1;
    bus = '0;
    ram_addr = '0;
    ram_wr = 1'b0;
    ep_dir_in = '0;
    fails = 0;
    comparisons = 0;
    seed = 32'h25f4;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h10, 8'h00);
    rd(8'h12, 8'h00);
    repeat (3)
    begin
      v = 8'($random(seed));
      wr(8'h10, {1'b1, v[6:0]});
      rd(8'h10, {1'b1, v[6:0]});
      ep_dir_in <= v[3:0];
      @(posedge clk);
      @(negedge clk);
      chk("ep_mode_out", 8'(ep_mode_out), 8'(v[3:0]));
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h1f, 8'(i << 6));
      @(posedge clk);
      @(negedge clk);
      chk("ep_count", 8'(ep_count), i[0] ? 8'h05 : 8'h03);
    end
    ram(8'hd8, 1'b1);
    wr(8'h10, 8'h05);
    tok(UAEC_TOK_IN, 7'h05, 1'b0);
    wr(8'h10, 8'h85);
    wr(8'h12, 8'h01);
    @(negedge clk);
    chk("ep0_rsp", 8'(ep0_rsp), 8'(UAEC_RSP_IGNORE));
    @(negedge clk);
    chk("ep0_rsp", 8'(ep0_rsp), 8'(UAEC_RSP_NAK));
    tok(UAEC_TOK_SETUP, 7'h06, 1'b0);
    chk("ep0_rsp", 8'(ep0_rsp), 8'(UAEC_RSP_ACCEPT));
    tok(UAEC_TOK_OUT, 7'h06, 1'b0);
    tok(UAEC_TOK_IN, 7'h05, 1'b1);
    // locked: lower bits survive the write, bit7 stays clear
    wr(8'h12, 8'h00);
    rd(8'h12, 8'h41);
    wr(8'h12, 8'h02);
    rd(8'h12, 8'h02);
    @(negedge clk);
    chk("ep0_rsp", 8'(ep0_rsp), 8'(UAEC_RSP_OTHER));
    tok(UAEC_TOK_OUT, 7'h05, 1'b1);
    uaec_host_model_i.pulse(2);
    rd(8'h12, 8'h32);
    wr(8'h12, 8'h02);
    // setup from mode 2 forces mode 1 and guards the ep0 fifo
    tok(UAEC_TOK_SETUP, 7'h05, 1'b1);
    uaec_host_model_i.pulse(0);
    ram(8'hb8, 1'b0);
    ram(8'hf8, 1'b1);
    // small layout moves the guarded ep0 fifo to the top of ram
    wr(8'h1f, 8'h40);
    ram(8'hf8, 1'b0);
    ram(8'hb8, 1'b1);
    rd(8'h12, 8'h81);
    wr(8'h12, 8'h00);
    rd(8'h12, 8'h80);
    uaec_host_model_i.pulse(1);
    // firmware reads once more before it clears the setup flag
    rd(8'h12, 8'h80);
    wr(8'h12, 8'h80);
    rd(8'h12, 8'h00);
    uaec_host_model_i.pulse(3);
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      n += int'(cpu_stall);
    end
    chk("cpu_stall", 8'(n), 8'h03);
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule
